// ---- src/dltc_top.v ----
// Purpose: Two legacy counter/timers with their shared control and mode registers.
// Assumes: Pins are asynchronous and synchronised here; bus is synchronous; interrupt enables and vectoring live in the CPU.
// Notes: Register reads answer one cycle after the read strobe.
// Summary of operation
// - Mode 0: high byte holds count bits 12-5, low byte bits 4-0.
// - Mode 0 wrap from all ones to zero sets the overflow flag.
// - Counter select one: count falling edges on the count pin.
// - Counter select zero: count system clock or prescaled clock per clock select.
// - Count only with run set and gate off or interrupt pin high, except in split mode (high byte needs run only, timer 1 neither).
// - Setting run never clears or reloads the count.
// - Timer 1 mirrors timer 0 in modes 0-2 with its own bits.
// - Mode 2: low byte counts, reloads from high byte on wrap, sets flag.
// - Split mode: low byte is timer 0's counter with its own bits.
// - Split mode: high byte counts internal clock under timer 1 run, sets timer 1 flag.
// - Split mode: timer 1 runs in modes 0-2, no flag, overflow still output.
// - Overflow flags set by hardware, cleared by software or vectoring.
// - Interrupt flags: level follows inverted pin, or set on falling edge.
// - Control register is bit addressable, resets to zero, fixed layout.
// - Mode register resets to zero with gate, select and mode per timer.
// - Timer 1 mode 3 holds its count.
// - Prescaler gives divide by 12, 4, 48, or external divide by 8.
`timescale 1ns/1ps
`include "dltc_regs.vh"
module dltc_top
(
	input  wire       clock_i,
	input  wire       rst_i,
	input  wire [7:0] sfr_addr_i,
	input  wire [7:0] sfr_wdata_i,
	input  wire       sfr_we_i,
	input  wire       sfr_re_i,
	input  wire       sfr_bit_we_i,
	input  wire [2:0] sfr_bit_idx_i,
	input  wire       sfr_bit_val_i,
	output wire [7:0] sfr_rdata_o,
	input  wire       vector_t0_i,
	input  wire       vector_t1_i,
	input  wire       vector_ext0_i,
	input  wire       vector_ext1_i,
	input  wire       count_pin_zero_i,
	input  wire       count_pin_one_i,
	input  wire       ext_irq0_n_input_i,
	input  wire       ext_irq1_n_input_i,
	input  wire       ext_clock_i,
	output wire       timer0_overflow_flag_o,
	output wire       timer1_overflow_flag_o,
	output wire       ext_irq0_flag_o,
	output wire       ext_irq1_flag_o,
	output wire       timer1_overflow_pulse_o
);
	reg  [7:0]  timer_control_r;
	reg  [7:0]  timer_mode_r;
	reg  [7:0]  timer_clock_config_r;
	reg  [7:0]  timer0_low_byte_r;
	reg  [7:0]  timer0_high_byte_r;
	reg  [7:0]  timer1_low_byte_r;
	reg  [7:0]  timer1_high_byte_r;
	reg  [7:0]  rdata_r;
	reg         t1_ovf_pulse_r;

	reg  [7:0]  timer_control_nxt;
	reg  [7:0]  tc_sw;
	reg  [7:0]  rdata_nxt;
	reg  [16:0] t0_bump;
	reg  [16:0] t1_bump;
	reg  [7:0]  t0_lo_nxt;
	reg  [7:0]  t0_hi_nxt;
	reg  [7:0]  t1_lo_nxt;
	reg  [7:0]  t1_hi_nxt;
	reg         t0_ovf;
	reg         t1_ovf;
	reg         split_hi_ovf;

	wire        pin0_fall;
	wire        pin1_fall;
	wire        ext_irq0_n_input_level;
	wire        ext_irq0_n_input_fall;
	wire        ext_irq1_n_input_level;
	wire        ext_irq1_n_input_fall;
	wire        extclk_fall;
	wire        presc_tick;

	wire        wr_tc;
	wire        wr_tm;
	wire        wr_cc;
	wire        wr_t0l;
	wire        wr_t0h;
	wire        wr_t1l;
	wire        wr_t1h;
	wire [1:0]  t0_mode;
	wire [1:0]  t1_mode;
	wire        split;
	wire        t0_int_tick;
	wire        t1_int_tick;
	wire        t0_tick;
	wire        t1_tick;
	wire        t0_enable;
	wire        t1_enable;
	wire        t0_step;
	wire        t1_step;
	wire        hi_step;

	dltc_sync_fall u_sync_pin0
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (count_pin_zero_i),
		.level_o (),
		.fall_o  (pin0_fall)
	);

	dltc_sync_fall u_sync_pin1
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (count_pin_one_i),
		.level_o (),
		.fall_o  (pin1_fall)
	);

	dltc_sync_fall u_sync_ext_irq0_n_input
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (ext_irq0_n_input_i),
		.level_o (ext_irq0_n_input_level),
		.fall_o  (ext_irq0_n_input_fall)
	);

	dltc_sync_fall u_sync_ext_irq1_n_input
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (ext_irq1_n_input_i),
		.level_o (ext_irq1_n_input_level),
		.fall_o  (ext_irq1_n_input_fall)
	);

	dltc_sync_fall u_sync_extclk
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (ext_clock_i),
		.level_o (),
		.fall_o  (extclk_fall)
	);

	dltc_prescaler u_presc
	(
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.sel_i      (timer_clock_config_r[`DLTC_CC_PRESC_HI:`DLTC_CC_PRESC_LO]),
		.ext_fall_i (extclk_fall),
		.tick_o     (presc_tick)
	);

	// One increment of a timer in modes 0 to 2; bit 16 is the overflow.
	function [16:0] bump;
		input [1:0] mode;
		input [7:0] hi;
		input [7:0] lo;
		reg   [12:0] v13;
		begin
			v13 = {hi, lo[4:0]} + 13'h0001;
			case (mode)
				`DLTC_MODE_13BIT:
					// Bits 7-5 of the low byte are left as they stand.
					bump = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]};
				`DLTC_MODE_16BIT:
					bump = {1'b0, hi, lo} + 17'h0_0001;
				`DLTC_MODE_RELOAD:
					bump = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
				default:
					bump = {1'b0, hi, lo};
			endcase
		end
	endfunction

	assign wr_tc  = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_TIMER_CONTROL);
	assign wr_tm  = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_TIMER_MODE);
	assign wr_cc  = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_CLOCK_CONFIG);
	assign wr_t0l = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_T0_LOW);
	assign wr_t0h = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_T0_HIGH);
	assign wr_t1l = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_T1_LOW);
	assign wr_t1h = sfr_we_i & (sfr_addr_i == `DLTC_ADDR_T1_HIGH);

	assign t0_mode = timer_mode_r[`DLTC_TM_MODE0_HI:`DLTC_TM_MODE0_LO];
	assign t1_mode = timer_mode_r[`DLTC_TM_MODE1_HI:`DLTC_TM_MODE1_LO];
	assign split   = (t0_mode == `DLTC_MODE_SPLIT);

	assign t0_int_tick = timer_clock_config_r[`DLTC_CC_T0_SYSCLK] | presc_tick;
	assign t1_int_tick = timer_clock_config_r[`DLTC_CC_T1_SYSCLK] | presc_tick;
	assign t0_tick     = timer_mode_r[`DLTC_TM_CT0] ? pin0_fall : t0_int_tick;
	assign t1_tick     = timer_mode_r[`DLTC_TM_CT1] ? pin1_fall : t1_int_tick;

	// The gate looks at the synchronised interrupt pin level.
	assign t0_enable = timer_control_r[`DLTC_TC_TR0] & (~timer_mode_r[`DLTC_TM_TIMER0_GATE_ENABLE] | ext_irq0_n_input_level);
	assign t1_enable = timer_control_r[`DLTC_TC_TR1] & (~timer_mode_r[`DLTC_TM_TIMER1_GATE_ENABLE] | ext_irq1_n_input_level);

	assign t0_step = t0_enable & t0_tick;
	// In split mode timer 1 is run by its mode alone and sees only internal clocks.
	assign t1_step = (t1_mode != `DLTC_MODE_SPLIT) & (split ? t1_int_tick : (t1_enable & t1_tick));
	assign hi_step = timer_control_r[`DLTC_TC_TR1] & t0_int_tick;

	// Count update; a CPU write to a count byte wins over counting in that cycle.
	always @*
	begin
		t0_bump      = bump(t0_mode, timer0_high_byte_r, timer0_low_byte_r);
		t1_bump      = bump(t1_mode, timer1_high_byte_r, timer1_low_byte_r);
		t0_lo_nxt    = timer0_low_byte_r;
		t0_hi_nxt    = timer0_high_byte_r;
		t1_lo_nxt    = timer1_low_byte_r;
		t1_hi_nxt    = timer1_high_byte_r;
		t0_ovf       = 1'b0;
		t1_ovf       = 1'b0;
		split_hi_ovf = 1'b0;
		if (split)
		begin
			if (t0_step)
			begin
				t0_lo_nxt = timer0_low_byte_r + 8'h01;
				t0_ovf    = &timer0_low_byte_r;
			end
			if (hi_step)
			begin
				t0_hi_nxt    = timer0_high_byte_r + 8'h01;
				split_hi_ovf = &timer0_high_byte_r;
			end
		end
		else if (t0_step)
		begin
			{t0_ovf, t0_hi_nxt, t0_lo_nxt} = t0_bump;
		end
		if (t1_step)
		begin
			{t1_ovf, t1_hi_nxt, t1_lo_nxt} = t1_bump;
		end
		if (wr_t0l)
			t0_lo_nxt = sfr_wdata_i;
		if (wr_t0h)
			t0_hi_nxt = sfr_wdata_i;
		if (wr_t1l)
			t1_lo_nxt = sfr_wdata_i;
		if (wr_t1h)
			t1_hi_nxt = sfr_wdata_i;
	end

	// Control register: software view first, then hardware sets on top of it.
	always @*
	begin
		tc_sw = timer_control_r;
		if (wr_tc)
			tc_sw = sfr_wdata_i;
		else if (sfr_bit_we_i)
			tc_sw[sfr_bit_idx_i] = sfr_bit_val_i;
		timer_control_nxt = tc_sw;
		// Run bits only gate counting; they never touch the count bytes.
		timer_control_nxt[`DLTC_TC_TR0] = tc_sw[`DLTC_TC_TR0];
		// A hardware set in the same cycle as a clear is kept.
		timer_control_nxt[`DLTC_TC_TF0] = t0_ovf | (tc_sw[`DLTC_TC_TF0] & ~vector_t0_i);
		timer_control_nxt[`DLTC_TC_TF1] = split_hi_ovf | (~split & t1_ovf)
			| (tc_sw[`DLTC_TC_TF1] & ~vector_t1_i);
		if (tc_sw[`DLTC_TC_IT0])
			timer_control_nxt[`DLTC_TC_IE0] = ext_irq0_n_input_fall | (tc_sw[`DLTC_TC_IE0] & ~vector_ext0_i);
		else
			timer_control_nxt[`DLTC_TC_IE0] = ~ext_irq0_n_input_level;
		if (tc_sw[`DLTC_TC_IT1])
			timer_control_nxt[`DLTC_TC_IE1] = ext_irq1_n_input_fall | (tc_sw[`DLTC_TC_IE1] & ~vector_ext1_i);
		else
			timer_control_nxt[`DLTC_TC_IE1] = ~ext_irq1_n_input_level;
	end

	// Read mux; unmapped addresses read as zero.
	always @*
	begin
		case (sfr_addr_i)
			`DLTC_ADDR_TIMER_CONTROL: rdata_nxt = timer_control_r;
			`DLTC_ADDR_TIMER_MODE:    rdata_nxt = timer_mode_r;
			`DLTC_ADDR_CLOCK_CONFIG:  rdata_nxt = timer_clock_config_r;
			`DLTC_ADDR_T0_LOW:        rdata_nxt = timer0_low_byte_r;
			`DLTC_ADDR_T0_HIGH:       rdata_nxt = timer0_high_byte_r;
			`DLTC_ADDR_T1_LOW:        rdata_nxt = timer1_low_byte_r;
			`DLTC_ADDR_T1_HIGH:       rdata_nxt = timer1_high_byte_r;
			default:                  rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			timer_control_r      <= `DLTC_RESET_BYTE;
			timer_mode_r         <= `DLTC_RESET_BYTE;
			timer_clock_config_r <= `DLTC_RESET_BYTE;
			timer0_low_byte_r    <= `DLTC_RESET_BYTE;
			timer0_high_byte_r   <= `DLTC_RESET_BYTE;
			timer1_low_byte_r    <= `DLTC_RESET_BYTE;
			timer1_high_byte_r   <= `DLTC_RESET_BYTE;
			rdata_r              <= 8'h00;
			t1_ovf_pulse_r       <= 1'b0;
		end
		else
		begin
			timer_control_r    <= timer_control_nxt;
			timer0_low_byte_r  <= t0_lo_nxt;
			timer0_high_byte_r <= t0_hi_nxt;
			timer1_low_byte_r  <= t1_lo_nxt;
			timer1_high_byte_r <= t1_hi_nxt;
			// Timer 1 overflow still drives baud and conversion triggers in split mode.
			t1_ovf_pulse_r     <= t1_ovf;
			if (wr_tm)
				timer_mode_r <= sfr_wdata_i;
			if (wr_cc)
				timer_clock_config_r <= sfr_wdata_i & `DLTC_CC_WRITE_MASK;
			if (sfr_re_i)
				rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata_o             = rdata_r;
	assign timer0_overflow_flag_o  = timer_control_r[`DLTC_TC_TF0];
	assign timer1_overflow_flag_o  = timer_control_r[`DLTC_TC_TF1];
	assign ext_irq0_flag_o         = timer_control_r[`DLTC_TC_IE0];
	assign ext_irq1_flag_o         = timer_control_r[`DLTC_TC_IE1];
	assign timer1_overflow_pulse_o = t1_ovf_pulse_r;
endmodule // dltc_top

// ---- inc/dltc_regs.vh ----
// Purpose: Register map, field positions and timing counts for the dual legacy timer/counter.
// Assumes: Special function register addresses are eight bits wide.
// Notes: Definitions only; included by the design files.
`ifndef DLTC_REGS_VH
`define DLTC_REGS_VH

`define DLTC_ADDR_TIMER_CONTROL 8'h88
`define DLTC_ADDR_TIMER_MODE    8'h89
`define DLTC_ADDR_T0_LOW        8'h8A
`define DLTC_ADDR_T1_LOW        8'h8B
`define DLTC_ADDR_T0_HIGH       8'h8C
`define DLTC_ADDR_T1_HIGH       8'h8D
`define DLTC_ADDR_CLOCK_CONFIG  8'h8E

`define DLTC_RESET_BYTE         8'h00

// Timer control fields.
`define DLTC_TC_TF1             7
`define DLTC_TC_TR1             6
`define DLTC_TC_TF0             5
`define DLTC_TC_TR0             4
`define DLTC_TC_IE1             3
`define DLTC_TC_IT1             2
`define DLTC_TC_IE0             1
`define DLTC_TC_IT0             0

// Timer mode fields.
`define DLTC_TM_TIMER1_GATE_ENABLE           7
`define DLTC_TM_CT1             6
`define DLTC_TM_MODE1_HI        5
`define DLTC_TM_MODE1_LO        4
`define DLTC_TM_TIMER0_GATE_ENABLE           3
`define DLTC_TM_CT0             2
`define DLTC_TM_MODE0_HI        1
`define DLTC_TM_MODE0_LO        0

// Timer clock configuration fields.
`define DLTC_CC_T1_SYSCLK       4
`define DLTC_CC_T0_SYSCLK       3
`define DLTC_CC_PRESC_HI        1
`define DLTC_CC_PRESC_LO        0
`define DLTC_CC_WRITE_MASK      8'h1B

// Mode codes.
`define DLTC_MODE_13BIT         2'b00
`define DLTC_MODE_16BIT         2'b01
`define DLTC_MODE_RELOAD        2'b10
`define DLTC_MODE_SPLIT         2'b11

// Prescale select codes and their terminal counts (divide minus one).
`define DLTC_PRESC_DIV12        2'b00
`define DLTC_PRESC_DIV4         2'b01
`define DLTC_PRESC_DIV48        2'b10
`define DLTC_PRESC_EXT8         2'b11
`define DLTC_PRESC_TC12         6'h0B
`define DLTC_PRESC_TC4          6'h03
`define DLTC_PRESC_TC48         6'h2F
`define DLTC_PRESC_TC8          6'h07

`endif

// ---- src/dltc_sync_fall.v ----
// Purpose: Two-stage synchroniser with a falling-transition detector.
// Assumes: The input level is held for at least two clock cycles.
// Notes: Only the second stage feeds the edge detector.
`timescale 1ns/1ps
module dltc_sync_fall
(
	input  wire clock_i,
	input  wire rst_i,
	input  wire pin_i,
	output wire level_o,
	output wire fall_o
);
	reg meta_r;
	reg sync_r;
	reg prev_r;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end
		else
		begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	// A registered high sample followed by a low sample.
	assign fall_o  = prev_r & ~sync_r;
endmodule // dltc_sync_fall

// ---- src/dltc_prescaler.v ----
// Purpose: Prescaled timebase for both timers.
// Assumes: The external clock has already been synchronised.
// Notes: Emits a one-cycle tick per prescaled period.
`timescale 1ns/1ps
`include "dltc_regs.vh"
module dltc_prescaler
(
	input  wire       clock_i,
	input  wire       rst_i,
	input  wire [1:0] sel_i,
	input  wire       ext_fall_i,
	output wire       tick_o
);
	reg  [5:0] cnt_r;
	reg  [5:0] term;
	wire       adv;

	always @*
	begin
		case (sel_i)
			`DLTC_PRESC_DIV12: term = `DLTC_PRESC_TC12;
			`DLTC_PRESC_DIV4:  term = `DLTC_PRESC_TC4;
			`DLTC_PRESC_DIV48: term = `DLTC_PRESC_TC48;
			default:           term = `DLTC_PRESC_TC8;
		endcase
	end

	// External mode advances on external edges, the rest on every system clock.
	assign adv    = (sel_i == `DLTC_PRESC_EXT8) ? ext_fall_i : 1'b1;
	assign tick_o = adv & (cnt_r >= term);

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_r <= 6'h00;
		else if (adv)
			cnt_r <= (cnt_r >= term) ? 6'h00 : cnt_r + 6'h01;
	end
endmodule // dltc_prescaler

// ---- verif/dltc_top_props.sv ----
// Purpose: Port-level properties of the dual timer block.
// Assumes: Run, type and mode bits change only by software writes.
// Notes: Hardware-set flags are only checked where no set can race.
`timescale 1ns/1ps
module dltc_top_props
(
	input wire       clock_i,
	input wire       rst_i,
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	input wire       sfr_we_i,
	input wire       sfr_re_i,
	input wire       sfr_bit_we_i,
	input wire [2:0] sfr_bit_idx_i,
	input wire       sfr_bit_val_i,
	input wire [7:0] sfr_rdata_o,
	input wire       vector_t0_i,
	input wire       vector_t1_i,
	input wire       vector_ext1_i,
	input wire       ext_irq0_n_input_i,
	input wire       ext_irq1_n_input_i,
	input wire       timer0_overflow_flag_o,
	input wire       timer1_overflow_flag_o,
	input wire       ext_irq0_flag_o,
	input wire       ext_irq1_flag_o,
	input wire       timer1_overflow_pulse_o
);
	reg [7:0] tc_r;
	reg [7:0] tm_r;
	// A shadow is exact only for bits that hardware never writes.
	always @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			tc_r <= 8'h00;
			tm_r <= 8'h00;
		end
		else
		begin
			if (sfr_we_i && sfr_addr_i == 8'h88)
				tc_r <= sfr_wdata_i;
			else if (sfr_bit_we_i)
				tc_r[sfr_bit_idx_i] <= sfr_bit_val_i;
			if (sfr_we_i && sfr_addr_i == 8'h89)
				tm_r <= sfr_wdata_i;
		end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	sequence s_mode_wr;
		sfr_we_i && sfr_addr_i == 8'h89;
	endsequence
	sequence s_mode_rd;
		!sfr_we_i ##1 !sfr_we_i ##1 sfr_re_i && !sfr_we_i && sfr_addr_i == 8'h89;
	endsequence
	// Matches a write strobe, two idle edges, then a read strobe; the wr and rd tasks back to back leave only one idle edge.
	a_mode_read_back: assert property (s_mode_wr ##1 s_mode_rd |=> sfr_rdata_o == $past(sfr_wdata_i, 4))
		else $error("mode register read back wrong");
	a_unmapped_zero: assert property (sfr_re_i && (sfr_addr_i < 8'h88 || sfr_addr_i > 8'h8E) |=> !sfr_rdata_o)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!sfr_re_i |=> $stable(sfr_rdata_o))
		else $error("read data moved without a read");
	a_level_follows: assert property ((!tc_r[0] && !ext_irq0_n_input_i) [*5] |-> ext_irq0_flag_o)
		else $error("level flag not following pin");
	a_edge_sets_flag: assert property (tc_r[2] && $fell(ext_irq1_n_input_i) |-> ##[1:5] ext_irq1_flag_o)
		else $error("falling edge did not set flag");
	a_edge_vector_clr: assert property (ext_irq1_n_input_i [*4] ##0 (tc_r[2] && vector_ext1_i) |=> !ext_irq1_flag_o)
		else $error("vector did not clear edge flag");
	a_tf0_vector_clr: assert property ((!tc_r[4]) [*2] ##0 vector_t0_i |=> !timer0_overflow_flag_o)
		else $error("vector did not clear timer 0 flag");
	a_tf1_bit_clr: assert property ((!tc_r[6]) [*2] ##0 (sfr_bit_we_i && sfr_bit_idx_i == 3'h7 && !sfr_bit_val_i
		&& !sfr_we_i) |=> !timer1_overflow_flag_o)
		else $error("bit write did not clear timer 1 flag");
	a_pulse_sets_tf1: assert property (timer1_overflow_pulse_o && tm_r[1:0] != 2'h3 && !vector_t1_i
		|-> timer1_overflow_flag_o)
		else $error("timer 1 overflow without flag");
endmodule // dltc_top_props

bind dltc_top dltc_top_props i_dltc_top_props (.*);

// ---- verif/dltc_pin_model.sv ----
// Purpose: Far-side pins: count pulse trains and a free external clock.
// Assumes: go_i is held four cycles to request one train.
// Notes: Each level lasts two cycles, the fastest legal event rate.
`timescale 1ns/1ps
module dltc_pin_model
(
	input  wire       clock_i,
	input  wire       rst_i,
	input  wire       go_i,
	input  wire [3:0] n_i,
	output reg        count_pin_o,
	output reg        ext_clock_o
);
	reg [3:0] left_r;
	reg [1:0] ph_r;
	always @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			left_r <= 4'h0;
			ph_r <= 2'h0;
			count_pin_o <= 1'b1;
			ext_clock_o <= 1'b1;
		end
		else
		begin
			ph_r <= ph_r + 2'h1;
			ext_clock_o <= ~ph_r[1];
			// Loading on a phase boundary keeps the first low level full length.
			if (go_i && ph_r == 2'h3)
				left_r <= n_i;
			else if (ph_r == 2'h3 && left_r != 4'h0)
				left_r <= left_r - 4'h1;
			count_pin_o <= ~(ph_r[1] && left_r != 4'h0);
		end
endmodule // dltc_pin_model

// ---- verif/dltc_top_bench.sv ----
// Purpose: Self-checking bench for the dual timer block.
// Assumes: Strobes are one-cycle pulses set just after a rising edge.
// Notes: Reads are queued by the driver and compared by a monitor.
`timescale 1ns/1ps
module dltc_top_bench;
	reg         clock_i = 1'b0;
	reg         rst_i = 1'b1;
	reg  [7:0]  sfr_addr_i = 8'h00;
	reg  [7:0]  sfr_wdata_i = 8'h00;
	reg         sfr_we_i = 1'b0;
	reg         sfr_re_i = 1'b0;
	reg         sfr_bit_we_i = 1'b0;
	reg  [2:0]  sfr_bit_idx_i = 3'h0;
	reg         sfr_bit_val_i = 1'b0;
	reg         ext_irq0_n_input_i = 1'b1;
	reg         ext_irq1_n_input_i = 1'b1;
	reg  [3:0]  vec_r = 4'h0;
	reg  [3:0]  pulses_r = 4'h0;
	reg         go_r = 1'b0;
	reg         re_d = 1'b0;
	wire [7:0]  sfr_rdata_o;
	wire        count_pin_zero_i;
	wire        ext_clock_i;
	wire        timer0_overflow_flag_o;
	wire        timer1_overflow_flag_o;
	wire        ext_irq0_flag_o;
	wire        ext_irq1_flag_o;
	wire        timer1_overflow_pulse_o;
	wire        count_pin_one_i = count_pin_zero_i;
	wire        vector_t0_i = vec_r[0];
	wire        vector_t1_i = vec_r[1];
	wire        vector_ext0_i = vec_r[2];
	wire        vector_ext1_i = vec_r[3];
	wire [3:0]  flags_w = {ext_irq1_flag_o, ext_irq0_flag_o, timer1_overflow_flag_o, timer0_overflow_flag_o};
	reg  [15:0] exp_q[$];
	reg  [15:0] e;
	integer     miscompares = 0;
	integer     n_tests = 0;
	integer     i;
	integer     n;
	integer     divs [0:3] = '{12, 4, 48, 32};

	dltc_top i_dltc_top (.*);
	dltc_pin_model i_dltc_pin_model
	(
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.go_i        (go_r),
		.n_i         (pulses_r),
		.count_pin_o (count_pin_zero_i),
		.ext_clock_o (ext_clock_i)
	);

	task summarize;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task cmp_byte(input [7:0] x, input [7:0] g);
	begin
		n_tests = n_tests + 1;
		if (g !== x)
		begin
			miscompares = miscompares + 1;
			$display("MISMATCH read data expected %h seen %h", x, g);
		end
	end
	endtask
	// Flags are sampled mid-cycle so the launching edge has settled.
	task cmp_bit(input [1:0] k, input x);
	begin
		@(negedge clock_i);
		n_tests = n_tests + 1;
		if (flags_w[k] !== x)
		begin
			miscompares = miscompares + 1;
			$display("MISMATCH flag %0d expected %b seen %b", k, x, flags_w[k]);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge clock_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_we_i <= 1'b1;
		@(posedge clock_i);
		sfr_we_i <= 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [7:0] d, input [7:0] m);
	begin
		@(posedge clock_i);
		sfr_addr_i <= a;
		sfr_re_i <= 1'b1;
		exp_q.push_back({m, d & m});
		@(posedge clock_i);
		sfr_re_i <= 1'b0;
	end
	endtask
	task bitw(input [2:0] b, input v);
	begin
		@(posedge clock_i);
		sfr_bit_idx_i <= b;
		sfr_bit_val_i <= v;
		sfr_bit_we_i <= 1'b1;
		@(posedge clock_i);
		sfr_bit_we_i <= 1'b0;
	end
	endtask
	// The run bit stays set for exactly c count edges; c must be at least 2.
	task run_n(input [2:0] b, input integer c);
	begin
		bitw(b, 1'b1);
		repeat (c - 2) @(posedge clock_i);
		bitw(b, 1'b0);
	end
	endtask
	task vecp(input [1:0] k);
	begin
		@(posedge clock_i);
		vec_r[k] <= 1'b1;
		@(posedge clock_i);
		vec_r[k] <= 1'b0;
	end
	endtask

	initial
		forever #2.5 clock_i = ~clock_i;
	always @(posedge clock_i)
		re_d <= sfr_re_i;
	always @(negedge clock_i)
		if (re_d)
		begin
			e = exp_q.pop_front();
			cmp_byte(e[7:0], sfr_rdata_o & e[15:8]);
		end
	initial
	begin
		#200000;
		miscompares = miscompares + 1;
		summarize;
	end

	initial
	begin
		n = $urandom(17);
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		for (i = 0; i < 9; i = i + 1)
			rd(8'h88 + i[7:0], 8'h00, 8'hFF);
		n = $urandom;
		wr(8'h89, n[7:0]);
		rd(8'h89, n[7:0], 8'hFF);
		wr(8'h8E, 8'hFF);
		rd(8'h8E, 8'h1B, 8'hFF);
		wr(8'h8E, 8'h18);
		wr(8'h89, 8'h01);
		wr(8'h8C, 8'hFF);
		wr(8'h8A, 8'hFD);
		run_n(3'h4, 2);
		rd(8'h8A, 8'hFF, 8'hFF);
		cmp_bit(2'h0, 1'b0);
		run_n(3'h4, 2);
		cmp_bit(2'h0, 1'b1);
		rd(8'h8A, 8'h01, 8'hFF);
		rd(8'h8C, 8'h00, 8'hFF);
		vecp(2'h0);
		cmp_bit(2'h0, 1'b0);
		wr(8'h89, 8'h00);
		wr(8'h8C, 8'hFF);
		wr(8'h8A, 8'hFE);
		run_n(3'h4, 2);
		cmp_bit(2'h0, 1'b1);
		rd(8'h8A, 8'h00, 8'h1F);
		rd(8'h8C, 8'h00, 8'hFF);
		bitw(3'h5, 1'b0);
		cmp_bit(2'h0, 1'b0);
		wr(8'h89, 8'h20);
		wr(8'h8D, 8'hA0);
		wr(8'h8B, 8'hFE);
		run_n(3'h6, 3);
		cmp_bit(2'h1, 1'b1);
		rd(8'h8B, 8'hA1, 8'hFF);
		rd(8'h8D, 8'hA0, 8'hFF);
		vecp(2'h1);
		cmp_bit(2'h1, 1'b0);
		wr(8'h89, 8'h09);
		wr(8'h8A, 8'h00);
		wr(8'h8C, 8'h00);
		@(posedge clock_i);
		ext_irq0_n_input_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		cmp_bit(2'h2, 1'b1);
		run_n(3'h4, 5);
		rd(8'h8A, 8'h00, 8'hFF);
		@(posedge clock_i);
		ext_irq0_n_input_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		run_n(3'h4, 3);
		rd(8'h8A, 8'h03, 8'hFF);
		cmp_bit(2'h2, 1'b0);
		wr(8'h89, 8'h05);
		wr(8'h8A, 8'h00);
		bitw(3'h4, 1'b1);
		n = 1 + $urandom % 15;
		@(posedge clock_i);
		pulses_r <= n[3:0];
		go_r <= 1'b1;
		repeat (4) @(posedge clock_i);
		go_r <= 1'b0;
		repeat (4 * n + 8) @(posedge clock_i);
		bitw(3'h4, 1'b0);
		rd(8'h8A, n[7:0], 8'hFF);
		wr(8'h89, 8'h01);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(8'h8E, 8'h10 | i[7:0]);
			wr(8'h8A, 8'h00);
			repeat (80) @(posedge clock_i);
			run_n(3'h4, 4 * divs[i]);
			rd(8'h8A, 8'h04, 8'hFF);
		end
		bitw(3'h2, 1'b1);
		@(posedge clock_i);
		ext_irq1_n_input_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		cmp_bit(2'h3, 1'b1);
		@(posedge clock_i);
		ext_irq1_n_input_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		vecp(2'h3);
		cmp_bit(2'h3, 1'b0);
		wr(8'h8E, 8'h18);
		wr(8'h89, 8'h03);
		wr(8'h8C, 8'hFF);
		run_n(3'h6, 2);
		cmp_bit(2'h1, 1'b1);
		rd(8'h8C, 8'h01, 8'hFF);
		bitw(3'h7, 1'b0);
		cmp_bit(2'h1, 1'b0);
		wr(8'h89, 8'h33);
		wr(8'h8B, 8'h00);
		wr(8'h89, 8'h13);
		repeat (8) @(posedge clock_i);
		wr(8'h89, 8'h33);
		repeat (6) @(posedge clock_i);
		rd(8'h8B, 8'h0A, 8'hFF);
		cmp_bit(2'h1, 1'b0);
		repeat (4) @(posedge clock_i);
		summarize;
	end
endmodule // dltc_top_bench
